// ==== hdl/atc_top.sv ====
// Purpose: Torque command path: analog conditioning, source select, limit, speed ceiling.
// Assumes: Analog codes come from another domain; motor speed is on clk_i.
// Notes: Registers sit on a classic Wishbone slave with one wait state.
// Behaviour
// - Mode value 4 selects torque regulation.
// - Analog off: target from percent parameter.
// - Analog on: torque follows selected input voltage.
// - Each channel publishes its conditioned value.
// - Each channel has millisecond low-pass filter.
// - Each channel has deadband in 0.01 V.
// - Each channel subtracts offset in 0.01 V.
// - Volt-to-torque scale held in mNm per volt.
// - Torque source: 0 percent, 1 ANALOG_INPUT_ONE, 2 ANALOG_INPUT_TWO.
// - Limit source: 0 off, 1 ANALOG_INPUT_ONE, 2 ANALOG_INPUT_TWO.
// - Volt-to-limit scale held in mNm per volt.
// - Torque limit applies in every operating mode.
// - Target torque is conditioned voltage times scale.
// - Torque ceiling is conditioned voltage times scale.
// - Conditioning order: filter, offset, then deadband.
// - Intermediate value is filtered input minus offset.
// - Speed ceiling gain sets speed limit strength.
// - Torque mode pulls torque back in proportion to speed above ceiling rpm.
// - Raw reading of each channel is readable.
module atc_top #(
   parameter int TICK_CYCLES = atc_pkg::TICK_CYCLES,
   parameter int RATED_MNM = atc_pkg::RATED_MNM
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] analog_input_one_raw_i,
   input wire logic [15:0] analog_input_two_raw_i,
   input wire logic signed [15:0] motor_speed_i,
   output logic signed [31:0] torque_cmd_o,
   output logic [31:0] torque_limit_o,
   output logic torque_limit_en_o,
   output logic torque_mode_o,
   output logic drive_enable_o,
   output logic overspeed_o
);
   // Register storage.
   atc_pkg::atc_chan_cfg_t cfg_reg [2];
   logic [7:0] tq_src_reg, lim_src_reg, mode_reg;
   logic [15:0] tq_scale_reg, lim_scale_reg, ctrl_reg, spd_ceil_reg, spd_gain_reg;
   logic signed [15:0] tq_pct_reg;
   // Bus state and decoded write strobe.
   atc_pkg::atc_bus_state_t bus_reg;
   logic wr_en;
   logic [31:0] rd_data;
   // Per-channel pipeline values.
   logic [15:0] raw_in [2];
   logic [15:0] raw_reg [2];
   logic signed [15:0] filt_reg [2], offc_reg [2], cond_reg [2];
   // Filter step divider.
   logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_reg;
   logic tick_reg;
   // Torque path intermediates.
   logic signed [31:0] tq_raw_reg, tq_clamp_reg;
   logic [31:0] lim_reg;
   logic signed [15:0] tq_sel, lim_sel;
   logic [16:0] spd_mag;
   logic signed [33:0] tq_red;

   assign raw_in[0] = analog_input_one_raw_i;
   assign raw_in[1] = analog_input_two_raw_i;
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && (bus_reg == atc_pkg::ATC_BUS_IDLE);

   // Number of right shifts that gives the filter a time constant near t ms.
   function automatic logic [3:0] filt_shift(input logic [15:0] t);
      logic [3:0] s;
      s = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (t[i]) begin
            s = (i == 15) ? 4'hF : 4'(i + 1);
         end
      end
      return s;
   endfunction

   // Free running divider that marks each filter step.
   always_ff @(posedge clk_i) begin
      if (rst_i || tick_cnt_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
      tick_reg <= !rst_i && tick_cnt_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
   end

   // Per-channel synchroniser and conditioning chain.
   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      logic [15:0] s1_reg, s2_reg, s3_reg;
      logic signed [15:0] volt;
      logic signed [16:0] fdiff, offs_d;
      logic signed [15:0] db;
      logic [16:0] mag;
      // Signed voltage in 0.01 V counts around mid-scale.
      assign volt = $signed(raw_reg[ch] - atc_pkg::ADC_MID);
      assign fdiff = 17'(volt) - 17'(filt_reg[ch]);
      assign offs_d = 17'(filt_reg[ch]) - 17'(cfg_reg[ch].offs);
      assign db = cfg_reg[ch].dead[15] ? 16'sh0000 : cfg_reg[ch].dead;
      assign mag = offc_reg[ch][15] ? 17'(-17'(offc_reg[ch])) : 17'(offc_reg[ch]);
      // Three flops; a new code is taken once the last two agree.
      always_ff @(posedge clk_i) begin
         s1_reg <= raw_in[ch];
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (rst_i) begin
            raw_reg[ch] <= atc_pkg::ADC_MID;
         end else if (s2_reg == s3_reg) begin
            raw_reg[ch] <= s3_reg;
         end
      end
      // Low-pass filter, bypassed when its time is zero.
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            filt_reg[ch] <= '0;
         end else if (cfg_reg[ch].filt == 16'h0000) begin
            filt_reg[ch] <= volt;
         end else if (tick_reg) begin
            filt_reg[ch] <= 16'(fdiff >>> filt_shift(cfg_reg[ch].filt)) + filt_reg[ch];
         end
      end
      // Offset subtraction with saturation, then deadband.
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            offc_reg[ch] <= '0;
            cond_reg[ch] <= '0;
         end else begin
            if (offs_d > 17'sd32767) begin
               offc_reg[ch] <= 16'sh7FFF;
            end else if (offs_d < -17'sd32768) begin
               offc_reg[ch] <= 16'sh8000;
            end else begin
               offc_reg[ch] <= 16'(offs_d);
            end
            if (mag <= 17'(db)) begin
               cond_reg[ch] <= '0;
            end else if (offc_reg[ch][15]) begin
               cond_reg[ch] <= offc_reg[ch] + db;
            end else begin
               cond_reg[ch] <= offc_reg[ch] - db;
            end
         end
      end
   end

   // Source selection of the setpoint and the limit voltage.
   assign tq_sel = (tq_src_reg == atc_pkg::SRC_ANALOG_INPUT_TWO) ? cond_reg[1] : cond_reg[0];
   assign lim_sel = (lim_src_reg == atc_pkg::SRC_ANALOG_INPUT_TWO) ? cond_reg[1] : cond_reg[0];

   // Setpoint and ceiling in mNm; the 0.01 V counts are divided down to volts.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tq_raw_reg <= '0;
         lim_reg <= '0;
         torque_limit_en_o <= 1'b0;
      end else begin
         if (tq_src_reg == atc_pkg::SRC_ANALOG_INPUT_ONE || tq_src_reg == atc_pkg::SRC_ANALOG_INPUT_TWO) begin
            tq_raw_reg <= 32'((34'(tq_sel) * $signed(34'(tq_scale_reg)))
                              / 34'(atc_pkg::CENTI_PER_VOLT));
         end else begin
            tq_raw_reg <= 32'((34'(tq_pct_reg) * 34'(RATED_MNM)) / 34'(atc_pkg::PCT_FULL));
         end
         lim_reg <= 32'((34'(lim_sel[15] ? 16'sh0000 : lim_sel) * 34'(lim_scale_reg))
                        / 34'(atc_pkg::CENTI_PER_VOLT));
         torque_limit_en_o <= lim_src_reg == atc_pkg::SRC_ANALOG_INPUT_ONE
                              || lim_src_reg == atc_pkg::SRC_ANALOG_INPUT_TWO;
      end
   end

   // Clamp to the analog ceiling in any mode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tq_clamp_reg <= '0;
      end else if (torque_limit_en_o && tq_raw_reg > $signed(lim_reg)) begin
         tq_clamp_reg <= $signed(lim_reg);
      end else if (torque_limit_en_o && tq_raw_reg < -$signed(lim_reg)) begin
         tq_clamp_reg <= -$signed(lim_reg);
      end else begin
         tq_clamp_reg <= tq_raw_reg;
      end
   end

   // Over the speed ceiling the torque is pulled back in proportion to the excess.
   assign spd_mag = motor_speed_i[15] ? 17'(-17'(motor_speed_i)) : 17'(motor_speed_i);
   assign tq_red = 34'(spd_mag - 17'(spd_ceil_reg)) * 34'(spd_gain_reg);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         torque_cmd_o <= '0;
         overspeed_o <= 1'b0;
         torque_mode_o <= 1'b0;
         drive_enable_o <= 1'b0;
         torque_limit_o <= '0;
      end else begin
         torque_mode_o <= mode_reg == atc_pkg::MODE_TORQUE;
         drive_enable_o <= ctrl_reg[3:0] == atc_pkg::CTRL_ENABLE;
         torque_limit_o <= lim_reg;
         overspeed_o <= mode_reg == atc_pkg::MODE_TORQUE && spd_mag > 17'(spd_ceil_reg);
         if (mode_reg != atc_pkg::MODE_TORQUE) begin
            torque_cmd_o <= '0;
         end else if (spd_mag > 17'(spd_ceil_reg)) begin
            torque_cmd_o <= motor_speed_i[15] ? 32'(34'(tq_clamp_reg) + tq_red)
                                              : 32'(34'(tq_clamp_reg) - tq_red);
         end else begin
            torque_cmd_o <= tq_clamp_reg;
         end
      end
   end

   // Register writes; 16-bit fields use lanes 0 and 1, 8-bit fields lane 0.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg[0] <= '0;
         cfg_reg[1] <= '0;
         tq_src_reg <= atc_pkg::RST_ZERO8;
         lim_src_reg <= atc_pkg::RST_ZERO8;
         mode_reg <= atc_pkg::RST_ZERO8;
         tq_scale_reg <= atc_pkg::RST_ZERO16;
         lim_scale_reg <= atc_pkg::RST_ZERO16;
         ctrl_reg <= atc_pkg::RST_ZERO16;
         tq_pct_reg <= atc_pkg::RST_ZERO16;
         spd_ceil_reg <= atc_pkg::RST_SPD_CEIL;
         spd_gain_reg <= atc_pkg::RST_SPD_GAIN;
      end else if (wr_en) begin
         for (int b = 0; b < 2; b++) begin
            if (wb_sel_i[b]) begin
               case (wb_adr_i)
                  atc_pkg::ADR_ANALOG_INPUT_ONE_FILT: cfg_reg[0].filt[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_ANALOG_INPUT_ONE_DEAD: cfg_reg[0].dead[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_ANALOG_INPUT_ONE_OFFS: cfg_reg[0].offs[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_ANALOG_INPUT_TWO_FILT: cfg_reg[1].filt[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_ANALOG_INPUT_TWO_DEAD: cfg_reg[1].dead[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_ANALOG_INPUT_TWO_OFFS: cfg_reg[1].offs[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_TQ_SCALE: tq_scale_reg[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_LIM_SCALE: lim_scale_reg[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_CTRL: ctrl_reg[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_TQ_PCT: tq_pct_reg[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_SPD_CEIL: spd_ceil_reg[b*8+:8] <= wb_dat_i[b*8+:8];
                  atc_pkg::ADR_SPD_GAIN: spd_gain_reg[b*8+:8] <= wb_dat_i[b*8+:8];
                  default: ;
               endcase
            end
         end
         if (wb_sel_i[0]) begin
            case (wb_adr_i)
               atc_pkg::ADR_TQ_SRC: tq_src_reg <= wb_dat_i[7:0];
               atc_pkg::ADR_LIM_SRC: lim_src_reg <= wb_dat_i[7:0];
               atc_pkg::ADR_MODE: mode_reg <= wb_dat_i[7:0];
               default: ;
            endcase
         end
      end
   end

   // Read multiplexer; unmapped addresses read zero.
   always_comb begin
      case (wb_adr_i)
         atc_pkg::ADR_ANALOG_INPUT_ONE_RAW: rd_data = {16'h0000, raw_reg[0]};
         atc_pkg::ADR_ANALOG_INPUT_TWO_RAW: rd_data = {16'h0000, raw_reg[1]};
         atc_pkg::ADR_ANALOG_INPUT_ONE_COND: rd_data = {16'h0000, cond_reg[0]};
         atc_pkg::ADR_ANALOG_INPUT_TWO_COND: rd_data = {16'h0000, cond_reg[1]};
         atc_pkg::ADR_ANALOG_INPUT_ONE_FILT: rd_data = {16'h0000, cfg_reg[0].filt};
         atc_pkg::ADR_ANALOG_INPUT_ONE_DEAD: rd_data = {16'h0000, cfg_reg[0].dead};
         atc_pkg::ADR_ANALOG_INPUT_ONE_OFFS: rd_data = {16'h0000, cfg_reg[0].offs};
         atc_pkg::ADR_ANALOG_INPUT_TWO_FILT: rd_data = {16'h0000, cfg_reg[1].filt};
         atc_pkg::ADR_ANALOG_INPUT_TWO_DEAD: rd_data = {16'h0000, cfg_reg[1].dead};
         atc_pkg::ADR_ANALOG_INPUT_TWO_OFFS: rd_data = {16'h0000, cfg_reg[1].offs};
         atc_pkg::ADR_TQ_SRC: rd_data = {24'h00_0000, tq_src_reg};
         atc_pkg::ADR_LIM_SRC: rd_data = {24'h00_0000, lim_src_reg};
         atc_pkg::ADR_MODE: rd_data = {24'h00_0000, mode_reg};
         atc_pkg::ADR_TQ_SCALE: rd_data = {16'h0000, tq_scale_reg};
         atc_pkg::ADR_LIM_SCALE: rd_data = {16'h0000, lim_scale_reg};
         atc_pkg::ADR_CTRL: rd_data = {16'h0000, ctrl_reg};
         atc_pkg::ADR_TQ_PCT: rd_data = {16'h0000, tq_pct_reg};
         atc_pkg::ADR_SPD_CEIL: rd_data = {16'h0000, spd_ceil_reg};
         atc_pkg::ADR_SPD_GAIN: rd_data = {16'h0000, spd_gain_reg};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Bus handshake: ack one cycle after the request, then one idle cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_reg <= atc_pkg::ATC_BUS_IDLE;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         case (bus_reg)
            atc_pkg::ATC_BUS_IDLE: begin
               if (wb_cyc_i && wb_stb_i) begin
                  bus_reg <= atc_pkg::ATC_BUS_ACK;
                  wb_ack_o <= 1'b1;
                  wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
               end
            end
            atc_pkg::ATC_BUS_ACK: begin
               bus_reg <= atc_pkg::ATC_BUS_IDLE;
               wb_ack_o <= 1'b0;
            end
            default: bus_reg <= atc_pkg::ATC_BUS_IDLE;
         endcase
      end
   end

   // Checks.
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && bus_reg == atc_pkg::ATC_BUS_IDLE;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_bus_ack;
      @(posedge clk_i) disable iff (rst_i) s_req |=> s_ack_pulse;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("ack not a one-cycle pulse");
   property p_mode;
      @(posedge clk_i) disable iff (rst_i)
         torque_mode_o |-> $past(mode_reg) == atc_pkg::MODE_TORQUE;
   endproperty
   a_mode: assert property (p_mode) else $error("torque mode without mode 4");
   property p_no_cmd;
      @(posedge clk_i) disable iff (rst_i)
         mode_reg != atc_pkg::MODE_TORQUE |=> torque_cmd_o == 0;
   endproperty
   a_no_cmd: assert property (p_no_cmd) else $error("torque outside torque mode");
   property p_pct;
      @(posedge clk_i) disable iff (rst_i) tq_src_reg == atc_pkg::SRC_OFF |=>
         tq_raw_reg == 32'((34'($past(tq_pct_reg)) * 34'(RATED_MNM)) / 34'(atc_pkg::PCT_FULL));
   endproperty
   a_pct: assert property (p_pct) else $error("percent setpoint wrong");
   property p_dead;
      @(posedge clk_i) disable iff (rst_i)
         (offc_reg[0] == 0) [*2] |=> cond_reg[0] == 0;
   endproperty
   a_dead: assert property (p_dead) else $error("deadband passed zero input");
   property p_lim_en;
      @(posedge clk_i) disable iff (rst_i)
         lim_src_reg == atc_pkg::SRC_OFF |=> !torque_limit_en_o;
   endproperty
   a_lim_en: assert property (p_lim_en) else $error("limit on with source 0");
   property p_clamp;
      @(posedge clk_i) disable iff (rst_i)
         torque_limit_en_o && $stable(lim_reg) |=> tq_clamp_reg <= $signed($past(lim_reg));
   endproperty
   a_clamp: assert property (p_clamp) else $error("torque above ceiling");
   property p_bypass;
      @(posedge clk_i) disable iff (rst_i)
         cfg_reg[0].filt == 0 |=> filt_reg[0] == $signed($past(raw_reg[0]) - atc_pkg::ADC_MID);
   endproperty
   a_bypass: assert property (p_bypass) else $error("filter bypass wrong");
   property p_drive;
      @(posedge clk_i) disable iff (rst_i)
         ctrl_reg[3:0] == atc_pkg::CTRL_ENABLE |=> drive_enable_o;
   endproperty
   a_drive: assert property (p_drive) else $error("enable pattern ignored");
endmodule

// ==== hdl/atc_pkg.sv ====
// Purpose: Shared constants and types of the analog torque command block.
// Assumes: 50 MHz clock; every register offset below is a byte address.
// Notes: Voltages are held in counts of 0.01 V, torques in mNm.
package atc_pkg;
   // Register byte addresses.
   localparam logic [31:0] ADR_ANALOG_INPUT_ONE_RAW = 32'h2501_0610;
   localparam logic [31:0] ADR_ANALOG_INPUT_TWO_RAW = 32'h2501_0710;
   localparam logic [31:0] ADR_ANALOG_INPUT_ONE_FILT = 32'h2502_0110;
   localparam logic [31:0] ADR_ANALOG_INPUT_ONE_DEAD = 32'h2502_0210;
   localparam logic [31:0] ADR_ANALOG_INPUT_ONE_OFFS = 32'h2502_0310;
   localparam logic [31:0] ADR_ANALOG_INPUT_TWO_FILT = 32'h2502_0410;
   localparam logic [31:0] ADR_ANALOG_INPUT_TWO_DEAD = 32'h2502_0510;
   localparam logic [31:0] ADR_ANALOG_INPUT_TWO_OFFS = 32'h2502_0610;
   localparam logic [31:0] ADR_TQ_SRC = 32'h2502_0808;
   localparam logic [31:0] ADR_LIM_SRC = 32'h2502_0908;
   localparam logic [31:0] ADR_TQ_SCALE = 32'h2502_0B10;
   localparam logic [31:0] ADR_LIM_SCALE = 32'h2502_0C10;
   localparam logic [31:0] ADR_ANALOG_INPUT_ONE_COND = 32'h2502_0F10;
   localparam logic [31:0] ADR_ANALOG_INPUT_TWO_COND = 32'h2502_1010;
   localparam logic [31:0] ADR_CTRL = 32'h6040_0010;
   localparam logic [31:0] ADR_MODE = 32'h6060_0008;
   localparam logic [31:0] ADR_TQ_PCT = 32'h6071_0010;
   localparam logic [31:0] ADR_SPD_CEIL = 32'h6080_0010;
   localparam logic [31:0] ADR_SPD_GAIN = 32'h60F6_0310;
   // Mode and source encodings.
   localparam logic [7:0] MODE_TORQUE = 8'h04;
   localparam logic [7:0] SRC_OFF = 8'h00;
   localparam logic [7:0] SRC_ANALOG_INPUT_ONE = 8'h01;
   localparam logic [7:0] SRC_ANALOG_INPUT_TWO = 8'h02;
   localparam logic [3:0] CTRL_ENABLE = 4'hF;
   // Reset values.
   localparam logic [15:0] RST_ZERO16 = 16'h0000;
   localparam logic [7:0] RST_ZERO8 = 8'h00;
   localparam logic [15:0] RST_SPD_CEIL = 16'h0BB8;
   localparam logic [15:0] RST_SPD_GAIN = 16'h000A;
   // Raw converter code of zero volts; one code is 0.01 V.
   localparam logic [15:0] ADC_MID = 16'h8000;
   // Counts of 0.01 V per volt, and full scale of a percentage.
   localparam int CENTI_PER_VOLT = 100;
   localparam int PCT_FULL = 100;
   // Rated motor torque used by the percentage source.
   localparam int RATED_MNM = 1000;
   // Filter step time and its cycle count.
   localparam int CLK_HZ = 50_000_000;
   localparam int FILT_STEP_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * FILT_STEP_MS;
   // Per-channel conditioning settings.
   typedef struct packed {
      logic [15:0] filt;
      logic signed [15:0] dead;
      logic signed [15:0] offs;
   } atc_chan_cfg_t;
   // Wishbone slave state.
   typedef enum logic [0:0] {
      ATC_BUS_IDLE = 1'b0,
      ATC_BUS_ACK = 1'b1
   } atc_bus_state_t;
endpackage

// ==== bench/atc_ain_src.sv ====
// Purpose: Behavioural model of the two analog voltage sources.
// Assumes: Voltages are counts of 0.01 V; codes are offset binary.
// Notes: Codes change just after a clock edge, as a converter would.
module atc_ain_src (
   input wire logic clk_i,
   input wire logic signed [15:0] volt1_i,
   input wire logic signed [15:0] volt2_i,
   output logic [15:0] raw1_o,
   output logic [15:0] raw2_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Each code is the zero-volt midpoint plus the voltage in counts.
   always_ff @(posedge clk_i) begin
      raw1_o <= atc_pkg::ADC_MID + volt1_i;
      raw2_o <= atc_pkg::ADC_MID + volt2_i;
   end
endmodule

// ==== bench/tb_analog_torque_command.sv ====
// Purpose: Self-checking bench of the torque command block.
// Assumes: One-wait-state Wishbone slave, filter tick shortened to 8 cycles.
// Notes: Expected values are worked out here from volts, offsets and scales.
module tb_analog_torque_command;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0; // Bench clock.
   logic rst_i = 1'b1; // Reset, held at start.
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0; // Bus request.
   logic [31:0] wb_adr = 32'h0000_0000, wb_dat = 32'h0000_0000; // Address and data.
   logic [3:0] wb_sel = 4'h0; // Byte lanes.
   logic [31:0] wb_rdat; // Read data.
   logic wb_ack; // Slave answer.
   logic signed [15:0] volt1 = 16'h0000, volt2 = 16'h0000, speed = 16'h0000; // Stimulus.
   logic [15:0] raw1, raw2; // Converter codes.
   logic signed [31:0] tq_cmd; // Torque command.
   logic [31:0] tq_lim; // Torque ceiling.
   logic lim_en, tq_mode, drv_en, ovs; // Status flags.
   int error_cnt = 0, num_checks = 0; // Counters.
   int exp; // Scratch expectation.
   // Writable registers, swept by the readback loop.
   logic [31:0] rw_adr [15] = '{atc_pkg::ADR_ANALOG_INPUT_ONE_FILT, atc_pkg::ADR_ANALOG_INPUT_ONE_DEAD,
      atc_pkg::ADR_ANALOG_INPUT_ONE_OFFS, atc_pkg::ADR_ANALOG_INPUT_TWO_FILT, atc_pkg::ADR_ANALOG_INPUT_TWO_DEAD,
      atc_pkg::ADR_ANALOG_INPUT_TWO_OFFS, atc_pkg::ADR_TQ_SRC, atc_pkg::ADR_LIM_SRC,
      atc_pkg::ADR_TQ_SCALE, atc_pkg::ADR_LIM_SCALE, atc_pkg::ADR_CTRL,
      atc_pkg::ADR_MODE, atc_pkg::ADR_TQ_PCT, atc_pkg::ADR_SPD_CEIL, atc_pkg::ADR_SPD_GAIN};
   int volts [4] = '{500, -500, 250, 300}; // Above, below and on the deadband.
   atc_top #(.TICK_CYCLES(8), .RATED_MNM(1000)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .analog_input_one_raw_i(raw1), .analog_input_two_raw_i(raw2), .motor_speed_i(speed), .torque_cmd_o(tq_cmd),
      .torque_limit_o(tq_lim), .torque_limit_en_o(lim_en), .torque_mode_o(tq_mode),
      .drive_enable_o(drv_en), .overspeed_o(ovs));
   atc_ain_src u_src (.clk_i(clk_i), .volt1_i(volt1), .volt2_i(volt2),
      .raw1_o(raw1), .raw2_o(raw2));
   // Free-running 50 MHz clock.
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Compares a word result.
   task automatic chk_val(input logic [31:0] got, input logic [31:0] want, input string what);
      num_checks++;
      if (got !== want) begin
         error_cnt++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask
   // Compares a flag result.
   task automatic chk_bit(input logic got, input logic want, input string what);
      num_checks++;
      if (got !== want) begin
         error_cnt++;
         $display("Error at %0t: flag %s got %b", $time, what, got);
      end
   endtask
   // One classic cycle; lanes follow the width coded in the low address byte.
   task automatic wb_xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= (a[7:0] == 8'h08) ? 4'h1 : 4'h3;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         $display("Error at %0t: no bus answer", $time);
      end
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   // Register write.
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_xfer(1'b1, a, d, q);
   endtask
   // Register read with comparison.
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] want);
      logic [31:0] q;
      wb_xfer(1'b0, a, 32'h0000_0000, q);
      chk_val(q, want, "read");
   endtask
   // Deadband: zero inside the band, otherwise magnitude shrunk by it.
   function automatic int dband(input int x, input int d);
      if (x > d) return x - d;
      if (x < -d) return x + d;
      return 0;
   endfunction
   // Value at which the shift filter stops moving from zero toward x.
   function automatic int filt_settle(input int x, input int k);
      int y;
      y = 0;
      while (((x - y) >>> k) != 0) y = y + ((x - y) >>> k);
      return y;
   endfunction
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      stop_test();
   end
   // Main sequence.
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(atc_pkg::ADR_SPD_CEIL, 32'h0000_0BB8);
      rd_chk(atc_pkg::ADR_SPD_GAIN, 32'h0000_000A);
      wr(atc_pkg::ADR_ANALOG_INPUT_ONE_RAW, 32'h0000_1234);
      rd_chk(atc_pkg::ADR_ANALOG_INPUT_ONE_RAW, 32'h0000_8000);
      rd_chk(32'h2502_0A10, 32'h0000_0000);
      // Readback of every writable register, then cleared again.
      foreach (rw_adr[i]) begin
         wr(rw_adr[i], 32'h0000_A5C3 ^ i);
         rd_chk(rw_adr[i], (32'h0000_A5C3 ^ i) & (rw_adr[i][3] ? 32'hFF : 32'hFFFF));
         wr(rw_adr[i], 32'h0000_0000);
      end
      // Percentage source in torque mode; enable comes last.
      wr(atc_pkg::ADR_MODE, 32'h0000_0004);
      wr(atc_pkg::ADR_TQ_PCT, 32'h0000_0032);
      wr(atc_pkg::ADR_CTRL, 32'h0000_000F);
      repeat (20) @(posedge clk_i);
      chk_bit(tq_mode, 1'b1, "mode");
      chk_bit(drv_en, 1'b1, "enable");
      chk_val(tq_cmd, 500, "pct");
      wr(atc_pkg::ADR_TQ_PCT, 32'h0000_FFE2);
      repeat (20) @(posedge clk_i);
      chk_val(tq_cmd, -300, "pct neg");
      // First channel: offset 2 V, deadband 1 V, 1000 mNm per volt.
      wr(atc_pkg::ADR_ANALOG_INPUT_ONE_OFFS, 32'h0000_00C8);
      wr(atc_pkg::ADR_ANALOG_INPUT_ONE_DEAD, 32'h0000_0064);
      wr(atc_pkg::ADR_TQ_SCALE, 32'h0000_03E8);
      wr(atc_pkg::ADR_TQ_SRC, 32'h0000_0001);
      foreach (volts[i]) begin
         volt1 <= 16'(volts[i]);
         repeat (20) @(posedge clk_i);
         exp = dband(volts[i] - 200, 100);
         rd_chk(atc_pkg::ADR_ANALOG_INPUT_ONE_COND, exp & 32'hFFFF);
         chk_val(tq_cmd, exp * 1000 / 100, "analog_input_one torque");
      end
      // Second channel as limit outside torque mode, then as source.
      wr(atc_pkg::ADR_MODE, 32'h0000_0000);
      wr(atc_pkg::ADR_LIM_SCALE, 32'h0000_01F4);
      wr(atc_pkg::ADR_LIM_SRC, 32'h0000_0002);
      volt2 <= 16'sd300;
      repeat (20) @(posedge clk_i);
      chk_bit(lim_en, 1'b1, "limit en");
      chk_val(tq_lim, 1500, "limit");
      chk_val(tq_cmd, 0, "off mode");
      wr(atc_pkg::ADR_MODE, 32'h0000_0004);
      wr(atc_pkg::ADR_TQ_SRC, 32'h0000_0002);
      volt2 <= -16'sd300;
      repeat (20) @(posedge clk_i);
      // A negative limit voltage gives a zero ceiling, so the command is clamped to zero.
      chk_val(tq_cmd, 0, "analog_input_two clamped");
      chk_val(tq_lim, 0, "neg limit");
      rd_chk(atc_pkg::ADR_ANALOG_INPUT_TWO_RAW, 32'h0000_7ED4);
      rd_chk(atc_pkg::ADR_ANALOG_INPUT_TWO_COND, 32'h0000_FED4);
      wr(atc_pkg::ADR_LIM_SRC, 32'h0000_0000);
      repeat (20) @(posedge clk_i);
      chk_bit(lim_en, 1'b0, "limit off");
      chk_val(tq_cmd, -3000, "analog_input_two torque");
      // Speed ceiling 100 rpm with gain 10 and 80 percent torque.
      wr(atc_pkg::ADR_TQ_SRC, 32'h0000_0000);
      wr(atc_pkg::ADR_TQ_PCT, 32'h0000_0050);
      wr(atc_pkg::ADR_SPD_CEIL, 32'h0000_0064);
      wr(atc_pkg::ADR_SPD_GAIN, 32'h0000_000A);
      speed <= 16'sd150;
      repeat (20) @(posedge clk_i);
      chk_bit(ovs, 1'b1, "over");
      chk_val(tq_cmd, 300, "over pos");
      speed <= -16'sd150;
      repeat (20) @(posedge clk_i);
      chk_val(tq_cmd, 1300, "over neg");
      speed <= 16'sd100;
      repeat (20) @(posedge clk_i);
      chk_bit(ovs, 1'b0, "at ceiling");
      // Filter time 4 ms: shift of 3 bits per tick from a settled zero.
      wr(atc_pkg::ADR_ANALOG_INPUT_ONE_OFFS, 32'h0000_0000);
      wr(atc_pkg::ADR_ANALOG_INPUT_ONE_DEAD, 32'h0000_0000);
      volt1 <= 16'sd0;
      repeat (20) @(posedge clk_i);
      wr(atc_pkg::ADR_ANALOG_INPUT_ONE_FILT, 32'h0000_0004);
      volt1 <= 16'sd800;
      repeat (800) @(posedge clk_i);
      rd_chk(atc_pkg::ADR_ANALOG_INPUT_ONE_COND, filt_settle(800, 3));
      stop_test();
   end
endmodule
